// File: rtl/ecd_proc_dispatch.sv
/*
 * processor end: decodes the three-word escape and sends the coprocessor
 * instruction then the derived address over two instruction-bus cycles.
 * assumes the three words arrive in one strobe and index registers are given flat.
 */
// Overview of operation
// - recognise escape by top eight bits
// - bit 9 set marks three-word sequence
// - bits 10-11 select coprocessor 0 to 3
// - bits 12-15 name index register, zero none
// - add index register to third word address
// - second word passed on uninterpreted
// - third word is operand base address
// - instruction then address on consecutive cycles
// - coprocessor takes bus via request and grant
// - with mmu, latch supplies state and key
// - coprocessor interrupts only after storing result
// - active-low request, grant to highest priority
// - holder drives lock; others wait meanwhile
module ecd_proc_dispatch
	import ecd_pkg::*;
(
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	input  wire logic                               esc_valid,
	output logic                                    esc_ready,
	input  wire logic [ECD_WORD_W-1:0]              esc_word0,
	input  wire logic [ECD_WORD_W-1:0]              esc_word1,
	input  wire logic [ECD_WORD_W-1:0]              esc_word2,
	input  wire logic [ECD_NUM_REGS*ECD_WORD_W-1:0] index_regs,
	input  wire logic [ECD_AS_W-1:0]                mmu_address_state,
	input  wire logic [ECD_AK_W-1:0]                mmu_access_key,
	output logic                                    esc_illegal,
	ecd_link_if.proc                                link
);
	logic [ECD_WORD_W-1:0] instr_reg;
	logic [ECD_WORD_W-1:0] addr_reg;
	logic [1:0]            sel_reg;
	ecd_xfer_t             kind_reg;
	logic [ECD_WORD_W-1:0] index_val;
	logic                  is_escape;
	logic                  bus_free;

	// opcode and sequence-marker check
	function automatic logic escape_ok(input logic [ECD_WORD_W-1:0] w);
		return (w[ECD_OPC_HI:ECD_OPC_LO] == ECD_ESC_OPCODE)
			&& w[ECD_SEQ_BIT];
	endfunction

	assign is_escape = escape_ok(esc_word0);
	assign bus_free  = link.bus_lock_n_i;
	// accept a new escape only when idle and nobody holds the bus
	assign esc_ready = (kind_reg == ECD_XFER_NONE) && bus_free;

	// index lookup, zero selects no offset
	always_comb begin
		index_val = '0;
		if (esc_word0[ECD_IDX_HI:ECD_IDX_LO] != ECD_NO_INDEX) begin
			index_val = index_regs[esc_word0[ECD_IDX_HI:ECD_IDX_LO]*ECD_WORD_W +: ECD_WORD_W];
		end
	end

	// capture words on acceptance of a legal escape
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			instr_reg <= '0;
			addr_reg  <= '0;
			sel_reg   <= '0;
		end else if (esc_valid && esc_ready && is_escape) begin
			instr_reg <= esc_word1;
			addr_reg  <= ECD_WORD_W'(esc_word2 + index_val);
			sel_reg   <= esc_word0[ECD_SEL_HI:ECD_SEL_LO];
		end
	end

	// two back-to-back bus cycles: instruction, then address
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			kind_reg <= ECD_XFER_NONE;
		end else begin
			case (kind_reg)
				ECD_XFER_NONE:  if (esc_valid && esc_ready && is_escape) kind_reg <= ECD_XFER_INSTR;
				ECD_XFER_INSTR: kind_reg <= ECD_XFER_ADDR;
				ECD_XFER_ADDR:  kind_reg <= ECD_XFER_NONE;
				default:        kind_reg <= ECD_XFER_NONE;
			endcase
		end
	end

	// a word offered but not an escape is flagged for one cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			esc_illegal <= 1'b0;
		end else begin
			esc_illegal <= esc_valid && esc_ready && !is_escape;
		end
	end

	// mmu state and key latched with the escape for the coprocessor
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.address_state <= '0;
			link.access_key    <= '0;
		end else if (esc_valid && esc_ready && is_escape) begin
			link.address_state <= mmu_address_state;
			link.access_key    <= mmu_access_key;
		end
	end

	assign link.ib_valid = (kind_reg != ECD_XFER_NONE);
	assign link.ib_kind  = kind_reg;
	assign link.ib_sel   = sel_reg;
	assign link.ib_data  = (kind_reg == ECD_XFER_ADDR) ? addr_reg : instr_reg;
endmodule

// File: rtl/ecd_pkg.sv
/*
 * shared constants for the escape coprocessor dispatch link.
 * assumes a single processor clock and synchronous active-high reset.
 */
package ecd_pkg;
	localparam int          ECD_WORD_W      = 16;
	localparam logic [7:0]  ECD_ESC_OPCODE  = 8'h4F;
	// bit positions, msb-first numbering mapped to little-endian vector
	localparam int          ECD_OPC_HI      = 15;
	localparam int          ECD_OPC_LO      = 8;
	localparam int          ECD_SEQ_BIT     = 6;   // documented bit 9
	localparam int          ECD_SEL_HI      = 5;   // documented bits 10..11
	localparam int          ECD_SEL_LO      = 4;
	localparam int          ECD_IDX_HI      = 3;   // documented bits 12..15
	localparam int          ECD_IDX_LO      = 0;
	localparam int          ECD_NUM_REGS    = 16;
	localparam logic [3:0]  ECD_NO_INDEX    = 4'h0;
	localparam int          ECD_AS_W        = 4;
	localparam int          ECD_AK_W        = 4;

	typedef enum logic [1:0] {
		ECD_XFER_NONE,
		ECD_XFER_INSTR,
		ECD_XFER_ADDR
	} ecd_xfer_t;
endpackage

// File: rtl/ecd_link_if.sv
/*
 * link between processor dispatch end and coprocessor end.
 * assumes the bench resolves the open-drain arbitration wires from enables.
 */
interface ecd_link_if;
	import ecd_pkg::*;
	logic [ECD_WORD_W-1:0] ib_data;
	logic                  ib_valid;
	ecd_xfer_t             ib_kind;
	logic [1:0]            ib_sel;
	logic                  bus_req_n_o;
	logic                  bus_req_n_oe;
	logic                  bus_gnt_n;
	logic                  bus_lock_n_i;
	logic                  bus_lock_n_o;
	logic                  bus_lock_n_oe;
	logic [ECD_AS_W-1:0]   address_state;
	logic [ECD_AK_W-1:0]   access_key;

	modport proc (
		output ib_data, ib_valid, ib_kind, ib_sel, address_state, access_key,
		input  bus_lock_n_i
	);
	modport coproc (
		input  ib_data, ib_valid, ib_kind, ib_sel, address_state, access_key,
		input  bus_gnt_n, bus_lock_n_i,
		output bus_req_n_o, bus_req_n_oe, bus_lock_n_o, bus_lock_n_oe
	);
endinterface

// File: rtl/ecd_coproc_end.sv
/*
 * coprocessor end: captures instruction and address words for its own
 * selector, contends for the bus, and raises a done interrupt after store.
 * assumes the user side signals mem_req and result_stored.
 */
module ecd_coproc_end
	import ecd_pkg::*;
#(
	parameter logic [1:0] MY_SEL = 2'h0
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	output logic                       cmd_valid,
	output logic [ECD_WORD_W-1:0]      cmd_instr,
	output logic [ECD_WORD_W-1:0]      cmd_addr,
	output logic [ECD_AS_W-1:0]        cmd_address_state,
	output logic [ECD_AK_W-1:0]        cmd_access_key,
	input  wire logic                  mem_req,
	input  wire logic                  mem_done,
	output logic                       mem_go,
	input  wire logic                  result_stored,
	output logic                       user_irq,
	ecd_link_if.coproc                 link
);
	typedef enum logic [1:0] {ECD_BUS_IDLE, ECD_BUS_REQ, ECD_BUS_OWN} ecd_bus_t;
	ecd_bus_t bus_reg;
	logic     mine;

	assign mine = link.ib_valid && (link.ib_sel == MY_SEL);

	// capture both words of the sequence
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmd_instr <= '0;
			cmd_addr  <= '0;
			cmd_valid <= 1'b0;
			cmd_address_state <= '0;
			cmd_access_key    <= '0;
		end else begin
			cmd_valid <= 1'b0;
			if (mine && link.ib_kind == ECD_XFER_INSTR) begin
				cmd_instr <= link.ib_data;
			end
			if (mine && link.ib_kind == ECD_XFER_ADDR) begin
				cmd_addr  <= link.ib_data;
				cmd_valid <= 1'b1;
				cmd_address_state <= link.address_state;
				cmd_access_key    <= link.access_key;
			end
		end
	end

	// bus contention: request, wait grant with bus unlocked, hold lock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_reg <= ECD_BUS_IDLE;
		end else begin
			case (bus_reg)
				ECD_BUS_IDLE: if (mem_req) bus_reg <= ECD_BUS_REQ;
				ECD_BUS_REQ:  if (!link.bus_gnt_n && link.bus_lock_n_i) bus_reg <= ECD_BUS_OWN;
				ECD_BUS_OWN:  if (mem_done) bus_reg <= ECD_BUS_IDLE;
				default:      bus_reg <= ECD_BUS_IDLE;
			endcase
		end
	end

	assign link.bus_req_n_o   = 1'b0;
	assign link.bus_req_n_oe  = (bus_reg == ECD_BUS_REQ);
	assign link.bus_lock_n_o  = 1'b0;
	assign link.bus_lock_n_oe = (bus_reg == ECD_BUS_OWN);
	assign mem_go             = (bus_reg == ECD_BUS_OWN);

	// interrupt only once the result is in memory
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			user_irq <= 1'b0;
		end else begin
			user_irq <= result_stored;
		end
	end
endmodule

// File: tb/ecd_link_properties.sv
/* checker for the escape dispatch link.
 assumes one clock and synchronous active-high reset. */
module ecd_link_properties
	import ecd_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       ib_valid,
	input wire ecd_xfer_t  ib_kind,
	input wire logic [1:0] ib_sel,
	input wire logic       bus_req_n_o,
	input wire logic       bus_req_n_oe,
	input wire logic       bus_gnt_n,
	input wire logic       bus_lock_n_i,
	input wire logic       bus_lock_n_o,
	input wire logic       bus_lock_n_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// link word order and spacing
	instr_addr_a: assert property (ib_valid && ib_kind == ECD_XFER_INSTR |=> ib_kind == ECD_XFER_ADDR)
		else $error("no address after instruction");
	addr_order_a: assert property (ib_kind == ECD_XFER_ADDR |-> $past(ib_kind) == ECD_XFER_INSTR)
		else $error("address without instruction");
	addr_gap_a: assert property (ib_kind == ECD_XFER_ADDR |=> !ib_valid)
		else $error("third link cycle");
	sel_hold_a: assert property (ib_kind == ECD_XFER_ADDR |-> $stable(ib_sel))
		else $error("selector moved");
	lock_gate_a: assert property (ib_kind == ECD_XFER_INSTR |-> $past(bus_lock_n_i))
		else $error("escape sent while locked");
	// arbitration wires
	req_low_a: assert property (bus_req_n_oe |-> !bus_req_n_o && !bus_lock_n_oe)
		else $error("request not low or held with lock");
	lock_low_a: assert property (bus_lock_n_oe |-> !bus_lock_n_o && !bus_req_n_oe)
		else $error("lock not low or request still up");
	grant_take_a: assert property (bus_req_n_oe && !bus_gnt_n && bus_lock_n_i |=> bus_lock_n_oe)
		else $error("grant on free bus not taken");
	lock_wait_a: assert property (bus_req_n_oe && !bus_lock_n_i |=> !bus_lock_n_oe)
		else $error("bus taken while locked");
	grant_first_a: assert property ($rose(bus_lock_n_oe) |-> !$past(bus_gnt_n) && $past(bus_lock_n_i))
		else $error("bus taken without grant");
	cover property (ib_kind == ECD_XFER_ADDR);
	cover property ($rose(bus_lock_n_oe));
	cover property (!bus_lock_n_i && !bus_lock_n_oe);
endmodule

// File: tb/tb.sv
/* bench for both link ends.
 assumes the bench grants every request at once. */
module tb import ecd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [15:0] w0, w1, w2, ea; logic ec, ei;} ecd_row_t;
	logic         sys_clk = 0, rst = 1, esc_valid = 0, mem_req = 0, mem_done = 0;
	logic         result_stored = 0, other_lock = 0, seen_cmd, seen_ill;
	logic         esc_ready, esc_illegal, cmd_valid, mem_go, user_irq;
	logic [15:0]  w0 = 0, w1 = 0, w2 = 0, cmd_instr, cmd_addr;
	logic [255:0] idx_regs;
	logic [3:0]   mmu_as = 0, mmu_ak = 0, cmd_as, cmd_ak;
	int           err_total = 0, checks_done = 0;
	ecd_row_t rows [6] = '{'{16'h4F50, 16'hA5C3, 16'h1234, 16'h1234, 1, 0}, '{16'h4F53, 16'h0F0F, 16'hF000, 16'h2333, 1, 0},
		'{16'h4F5F, 16'hFFFF, 16'h0001, 16'h0000, 1, 0}, '{16'h4F62, 16'h1111, 16'h2222, 16'h4444, 0, 0},
		'{16'h4F10, 16'h2222, 16'h3333, 16'h0000, 0, 1}, '{16'h4E50, 16'h3333, 16'h4444, 16'h0000, 0, 1}};
	ecd_link_if link();
	// arbiter grants any request; lock wire is wired-and
	assign link.bus_gnt_n = !link.bus_req_n_oe;
	assign link.bus_lock_n_i = !(link.bus_lock_n_oe || other_lock);
	ecd_proc_dispatch u_ecd_proc_dispatch (.sys_clk(sys_clk), .rst(rst), .esc_valid(esc_valid), .esc_ready(esc_ready),
		.esc_word0(w0), .esc_word1(w1), .esc_word2(w2), .index_regs(idx_regs), .mmu_address_state(mmu_as),
		.mmu_access_key(mmu_ak), .esc_illegal(esc_illegal), .link(link));
	ecd_coproc_end #(.MY_SEL(2'h1)) u_ecd_coproc_end (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_instr(cmd_instr), .cmd_addr(cmd_addr), .cmd_address_state(cmd_as), .cmd_access_key(cmd_ak),
		.mem_req(mem_req),
		.mem_done(mem_done), .mem_go(mem_go), .result_stored(result_stored), .user_irq(user_irq), .link(link));
	ecd_link_properties u_ecd_link_properties (.sys_clk(sys_clk), .rst(rst), .ib_valid(link.ib_valid),
		.ib_kind(link.ib_kind), .ib_sel(link.ib_sel), .bus_req_n_o(link.bus_req_n_o), .bus_req_n_oe(link.bus_req_n_oe),
		.bus_gnt_n(link.bus_gnt_n), .bus_lock_n_i(link.bus_lock_n_i), .bus_lock_n_o(link.bus_lock_n_o),
		.bus_lock_n_oe(link.bus_lock_n_oe));
	// clock
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(string nm, logic e, logic g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// offer one escape and watch four cycles
	task automatic run_row(ecd_row_t r);
		seen_cmd = 0;
		seen_ill = 0;
		esc_valid = 1;
		{w0, w1, w2} = {r.w0, r.w1, r.w2};
		{mmu_as, mmu_ak} = {r.w1[3:0], r.w2[3:0]};
		while (esc_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1 esc_valid = 0;
		repeat (4) begin
			if (link.ib_kind === ECD_XFER_INSTR) chk16("ib_instr", r.w1, link.ib_data);
			if (link.ib_kind === ECD_XFER_ADDR) chk16("ib_addr", r.ea, link.ib_data);
			seen_cmd |= (cmd_valid === 1'b1);
			seen_ill |= (esc_illegal === 1'b1);
			@(posedge sys_clk);
			#1;
		end
		chk1("cmd_valid", r.ec, seen_cmd);
		chk1("illegal", r.ei, seen_ill);
		if (r.ec) begin
			chk16("cmd_instr", r.w1, cmd_instr);
			chk16("cmd_addr", r.ea, cmd_addr);
			chk16("cmd_as", 16'(r.w1[3:0]), 16'(cmd_as));
			chk16("cmd_ak", 16'(r.w2[3:0]), 16'(cmd_ak));
		end
		$display("row %h done", r.w0);
	endtask
	// main sequence
	initial begin
		idx_regs[15:0] = 16'hFFFF;
		for (int n = 1; n < 16; n++) idx_regs[n*16+:16] = 16'(16'h1111 * n);
		repeat (5) @(posedge sys_clk);
		#1 rst = 0;
		chk1("ready_rst", 1, esc_ready);
		foreach (rows[i]) run_row(rows[i]);
		// legal escape under a foreign lock waits, then goes once free
		{w0, w1, w2} = {16'h4F50, 16'h5A5A, 16'h0042};
		other_lock = 1;
		esc_valid = 1;
		repeat (3) @(posedge sys_clk);
		#1 chk1("locked_ib", 0, link.ib_valid);
		chk1("locked_ill", 0, esc_illegal);
		other_lock = 0;
		@(posedge sys_clk);
		#1 esc_valid = 0;
		chk1("unlocked_ib", 1, link.ib_valid);
		repeat (3) @(posedge sys_clk);
		#1 chk16("late_instr", 16'h5A5A, cmd_instr);
		chk16("late_addr", 16'h0042, cmd_addr);
		$display("foreign lock done");
		// coprocessor request waits out a foreign lock, then takes the bus
		other_lock = 1;
		mem_req = 1;
		repeat (3) @(posedge sys_clk);
		#1 chk1("wait_go", 0, mem_go);
		chk1("wait_req", 1, link.bus_req_n_oe);
		other_lock = 0;
		do begin
			@(posedge sys_clk);
			#1;
		end while (mem_go !== 1'b1);
		mem_req = 0;
		chk1("req_drop", 0, link.bus_req_n_oe);
		chk1("lock_wire", 0, link.bus_lock_n_i);
		chk1("ready_busy", 0, esc_ready);
		chk1("irq_early", 0, user_irq);
		{mem_done, result_stored} = 2'h3;
		@(posedge sys_clk);
		#1 {mem_done, result_stored} = 2'h0;
		chk1("mem_go", 0, mem_go);
		chk1("user_irq", 1, user_irq);
		$display("bus tenure done");
		// reset in mid-transfer clears link and captured command
		{w0, w1, w2} = {16'h4F50, 16'h7777, 16'h0100};
		esc_valid = 1;
		@(posedge sys_clk);
		#1 {esc_valid, rst} = 2'b01;
		chk1("pre_rst_ib", 1, link.ib_valid);
		@(posedge sys_clk);
		#1 chk1("rst_ib", 0, link.ib_valid);
		chk16("rst_instr", 16'h0000, cmd_instr);
		chk1("rst_ready", 1, esc_ready);
		rst = 0;
		run_row(rows[1]);
		$display("mid-run reset done");
		give_verdict();
	end
	// watchdog
	initial begin
		#5000;
		err_total++;
		give_verdict();
	end
endmodule
